// ===== design/pmon_consts.svh
// Overview of operation
// R1: Current, bus voltage, die temperature, power, energy and charge are each read from own address.
// R2: Codes carry fixed weights of 2.4 mA, 3.125 mV, 125 mC-deg, 480 uW, 7.68 mJ and 150 uC.
// R3: Current, bus voltage and temperature codes are two's complement numbers.
// R4: Bus voltage is a 16-bit signed field that never goes negative, 85 V at the silicon limit.
// R5: The bus voltage code range reaches the equivalent of 102.4 V.
// R6: Die temperature is a 12-bit signed field spanning -256 to +256 degrees.
// R7: Current is a 16-bit signed field covering plus or minus 78.64 A.
// R8: The 40-bit energy accumulator wraps to zero on overflow with no indication.
// R9: Writing the accumulator clear bit zeroes the energy accumulator at any time; a clear in the cycle of a result update leaves that update's power.
// R10: Overflow of the 40-bit charge accumulator sets the charge overflow flag.
// R11: After a charge overflow the host clears the charge accumulator with the clear bit.
// R12: Conversion times of 50, 84, 150, 280, 540, 1052, 2074 and 4120 us are selectable.
// R13: Averaging over a selectable sample count gives one result per conversion time times count.
// R14: Multi-byte results go out most significant byte first.
// R15: Results update once per output sample, power, energy and charge from the same averages.
// R16: The charge overflow flag holds until the clear action, which clears it with the charge.
`ifndef PMON_CONSTS_SVH
`define PMON_CONSTS_SVH

// register pointers
`define REG_CONFIG 8'h00
`define REG_BUS 8'h05
`define REG_TEMP 8'h06
`define REG_CURRENT 8'h07
`define REG_POWER 8'h08
`define REG_ENERGY 8'h09
`define REG_CHARGE 8'h0a

// config byte layout and reset
`define CFG_ACCUMULATOR_CLEAR_BIT_BIT 7
`define CFG_CONV_LSB 3
`define CFG_AVG_LSB 0
`define CFG_CHOF_BIT 8
`define CFG_CONV_RESET 3'h5
`define CFG_AVG_RESET 3'h0

// power code = |current| * bus >> shift (2.4 mA * 3.125 mV * 64 = 480 uW)
`define POWER_SHIFT 6

// timing
`define CLK_MHZ 200
`define CONV_US_0 50
`define CONV_US_1 84
`define CONV_US_2 150
`define CONV_US_3 280
`define CONV_US_4 540
`define CONV_US_5 1052
`define CONV_US_6 2074
`define CONV_US_7 4120

`endif

// ===== design/pmon_pkg.sv
package pmon_pkg;

    // state of the result register block
    typedef struct packed {
        logic [31:0] convCnt;
        logic convStart;
        logic [7:0] ptr;
        logic [2:0] convSel;
        logic [2:0] avgSel;
        logic [15:0] current;
        logic [15:0] busV;
        logic [11:0] temp;
        logic [23:0] power;
        logic [39:0] energy;
        logic [39:0] charge;
        logic charge_overflow_flag;
        logic [39:0] shiftReg;
        logic [2:0] bytesLeft;
        logic [7:0] byteData;
        logic byteValid;
    } pmon_state_t;

    // state of the averager
    typedef struct packed {
        logic [25:0] sumCur;
        logic [25:0] sumBus;
        logic [21:0] sumTemp;
        logic [10:0] cnt;
        logic done;
        logic [15:0] avgCur;
        logic [15:0] avgBus;
        logic [11:0] avgTemp;
    } avg_state_t;

endpackage : pmon_pkg

// ===== design/avg_if.sv
`timescale 1ns/10ps
`default_nettype none
interface avg_if;
    logic sampleValid;
    logic [15:0] sampleCur;
    logic [15:0] sampleBus;
    logic [11:0] sampleTemp;
    logic [2:0] avgSel;
    logic done;
    logic [15:0] avgCur;
    logic [15:0] avgBus;
    logic [11:0] avgTemp;

    modport averager (
        input sampleValid, sampleCur, sampleBus, sampleTemp, avgSel,
        output done, avgCur, avgBus, avgTemp
    );
    modport host (
        output sampleValid, sampleCur, sampleBus, sampleTemp, avgSel,
        input done, avgCur, avgBus, avgTemp
    );
endinterface : avg_if
`default_nettype wire

// ===== design/sample_averager.sv
`timescale 1ns/10ps
`default_nettype none
module sample_averager (
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // samples in, averages out
    avg_if.averager av
);
    import pmon_pkg::*;

    avg_state_t q, d;

    // averaging select to shift: 1, 4, 16, 64, 128, 256, 512, 1024
    function automatic logic [3:0] avgShift(input logic [2:0] sel);
        case (sel)
            3'h0: avgShift = 4'h0;
            3'h1: avgShift = 4'h2;
            3'h2: avgShift = 4'h4;
            default: avgShift = 4'(sel) + 4'h3;
        endcase
    endfunction : avgShift

    logic [10:0] lastIdx;
    logic [25:0] nCur, nBus;
    logic [21:0] nTemp;
    assign lastIdx = 11'((12'h1 << avgShift(av.avgSel)) - 12'h1);

    // accumulate signed sums, emit mean after the selected count
    always_comb begin
        d = q;
        d.done = 1'b0;
        nCur = q.sumCur + {{10{av.sampleCur[15]}}, av.sampleCur};
        nBus = q.sumBus + {{10{av.sampleBus[15]}}, av.sampleBus};
        nTemp = q.sumTemp + {{10{av.sampleTemp[11]}}, av.sampleTemp};
        if (av.sampleValid) begin
            if (q.cnt >= lastIdx) begin // see R13
                d.avgCur = 16'($signed(nCur) >>> avgShift(av.avgSel));
                d.avgBus = 16'($signed(nBus) >>> avgShift(av.avgSel));
                d.avgTemp = 12'($signed(nTemp) >>> avgShift(av.avgSel));
                d.done = 1'b1;
                d.sumCur = 26'h0;
                d.sumBus = 26'h0;
                d.sumTemp = 22'h0;
                d.cnt = 11'h0;
            end else begin
                d.sumCur = nCur;
                d.sumBus = nBus;
                d.sumTemp = nTemp;
                d.cnt = q.cnt + 11'h1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign av.done = q.done;
    assign av.avgCur = q.avgCur;
    assign av.avgBus = q.avgBus;
    assign av.avgTemp = q.avgTemp;

    property p_avgDone;
        @(posedge core_clk) disable iff (!arst_n)
        av.sampleValid && q.cnt >= lastIdx |=> av.done && q.cnt == 11'h0;
    endproperty
    a_avgDone: assert property (p_avgDone) else $error("average not emitted at count"); // see R13

    property p_noEarlyDone;
        @(posedge core_clk) disable iff (!arst_n)
        av.sampleValid && q.cnt < lastIdx |=> !av.done && q.cnt == $past(q.cnt) + 11'h1;
    endproperty
    a_noEarlyDone: assert property (p_noEarlyDone) else $error("average emitted early"); // see R13

    c_avgOfFour: cover property (@(posedge core_clk) disable iff (!arst_n)
        av.avgSel == 3'h1 && av.done);
endmodule : sample_averager
`default_nettype wire

// ===== design/power_monitor_result_registers.sv
`timescale 1ns/10ps
`default_nettype none
`include "pmon_consts.svh"
module power_monitor_result_registers #(
    parameter int unsigned CYC_PER_US = `CLK_MHZ,
    // accumulator width, 17 to 40; narrow only to reach wrap in short runs
    parameter int unsigned ACC_W = 40
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // converter side
    output logic convStart,
    input wire logic adcValid,
    input wire logic [15:0] adcCurrent,
    input wire logic [15:0] adcBus,
    input wire logic [11:0] adcTemp,
    // register port
    input wire logic ptrWr,
    input wire logic [7:0] ptrData,
    input wire logic cfgWr,
    input wire logic [7:0] cfgData,
    input wire logic rdStart,
    input wire logic byteRd,
    output logic [7:0] byteData,
    output logic byteValid,
    // status
    output logic chargeOverflow
);
    import pmon_pkg::*;

    pmon_state_t q, d;
    avg_if av ();

    // keeps the low ACC_W bits of an accumulator
    localparam logic [39:0] ACC_MASK = 40'((41'h1 << ACC_W) - 41'h1);

    // cycles in one conversion for a select code
    function automatic logic [31:0] convCycles(input logic [2:0] sel);
        int unsigned us;
        case (sel) // see R12
            3'h0: us = `CONV_US_0;
            3'h1: us = `CONV_US_1;
            3'h2: us = `CONV_US_2;
            3'h3: us = `CONV_US_3;
            3'h4: us = `CONV_US_4;
            3'h5: us = `CONV_US_5;
            3'h6: us = `CONV_US_6;
            default: us = `CONV_US_7;
        endcase
        convCycles = 32'(us * CYC_PER_US);
    endfunction : convCycles

    // bytes returned per register; unmapped pointers give two zero bytes
    function automatic logic [2:0] regBytes(input logic [7:0] p);
        case (p)
            `REG_POWER: regBytes = 3'h3;
            `REG_ENERGY, `REG_CHARGE: regBytes = 3'h5;
            default: regBytes = 3'h2;
        endcase
    endfunction : regBytes

    // register contents left-aligned in 40 bits, so the top byte goes first
    function automatic logic [39:0] regImage(input pmon_state_t s);
        case (s.ptr) // see R1
            `REG_CONFIG: regImage = {7'h0, s.charge_overflow_flag, 1'b0, 1'b0, s.convSel, s.avgSel, 24'h0};
            `REG_BUS: regImage = {s.busV, 24'h0};
            `REG_TEMP: regImage = {4'h0, s.temp, 24'h0};
            `REG_CURRENT: regImage = {s.current, 24'h0};
            `REG_POWER: regImage = {s.power, 16'h0};
            `REG_ENERGY: regImage = s.energy;
            `REG_CHARGE: regImage = s.charge;
            default: regImage = 40'h0;
        endcase
    endfunction : regImage

    // adc samples arrive on core_clk, no synchroniser needed
    assign av.sampleValid = adcValid;
    assign av.sampleCur = adcCurrent;
    assign av.sampleBus = adcBus;
    assign av.sampleTemp = adcTemp;
    assign av.avgSel = q.avgSel;

    sample_averager u_avg (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .av(av.averager)
    );

    logic clrAcc;
    logic [15:0] absCur;
    logic [31:0] prod;
    logic [23:0] pw;
    logic [39:0] pwExt;
    logic [40:0] chgSum;
    logic chgCarry;

    // power from the same averaged pair that updates current and voltage
    assign clrAcc = cfgWr && cfgData[`CFG_ACCUMULATOR_CLEAR_BIT_BIT];
    assign absCur = av.avgCur[15] ? 16'(-av.avgCur) : av.avgCur; // see R3
    assign prod = absCur * (av.avgBus[15] ? 16'h0 : av.avgBus);
    assign pw = 24'(prod >> `POWER_SHIFT); // see R2
    assign pwExt = {16'h0, pw};
    assign chgSum = {1'b0, clrAcc ? 40'h0 : q.charge} + {25'h0, absCur};
    assign chgCarry = chgSum[ACC_W]; // carry out of the configured width

    // conversion timer, config, result update and byte readout
    always_comb begin
        d = q;
        d.convStart = 1'b0;
        d.byteValid = 1'b0;
        if (q.convCnt >= convCycles(q.convSel) - 32'h1) begin // see R12
            d.convCnt = 32'h0;
            d.convStart = 1'b1;
        end else begin
            d.convCnt = q.convCnt + 32'h1;
        end
        if (cfgWr) begin
            // restart the period so the count never sits above a shorter new end
            d.convCnt = 32'h0;
            d.convSel = cfgData[`CFG_CONV_LSB +: 3];
            d.avgSel = cfgData[`CFG_AVG_LSB +: 3];
        end
        if (clrAcc) begin
            d.energy = 40'h0; // see R9
            d.charge = 40'h0; // see R11
            d.charge_overflow_flag = 1'b0; // see R16
        end
        if (av.done) begin // see R15
            d.current = av.avgCur; // see R7
            d.busV = av.avgBus[15] ? 16'h0 : av.avgBus; // see R4, R5
            d.temp = av.avgTemp; // see R6
            d.power = pw;
            // wraps silently, a clear in the same cycle drops the old total
            d.energy = ((clrAcc ? 40'h0 : q.energy) + pwExt) & ACC_MASK; // see R8
            d.charge = chgSum[39:0] & ACC_MASK;
            // overflow set wins over a simultaneous clear
            if (chgCarry) begin
                d.charge_overflow_flag = 1'b1; // see R10
            end
        end
        if (ptrWr) begin
            d.ptr = ptrData;
        end
        if (rdStart) begin
            d.shiftReg = regImage(q);
            d.bytesLeft = regBytes(q.ptr);
        end else if (byteRd) begin
            d.byteData = q.shiftReg[39:32]; // see R14
            d.byteValid = 1'b1;
            d.shiftReg = {q.shiftReg[31:0], 8'h0};
            d.bytesLeft = (q.bytesLeft == 3'h0) ? 3'h0 : q.bytesLeft - 3'h1;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
            q.convSel <= `CFG_CONV_RESET;
            q.avgSel <= `CFG_AVG_RESET;
        end else begin
            q <= d;
        end
    end

    assign convStart = q.convStart;
    assign byteData = q.byteData;
    assign byteValid = q.byteValid;
    assign chargeOverflow = q.charge_overflow_flag;

    property p_busNonNeg;
        @(posedge core_clk) disable iff (!arst_n)
        av.done && av.avgBus[15] |=> q.busV == 16'h0;
    endproperty
    a_busNonNeg: assert property (p_busNonNeg) else $error("bus voltage went negative"); // see R4

    property p_convPeriod;
        @(posedge core_clk) disable iff (!arst_n)
        convStart && !$past(cfgWr) |-> $past(q.convCnt) == convCycles(q.convSel) - 32'h1;
    endproperty
    a_convPeriod: assert property (p_convPeriod) else $error("conversion period wrong"); // see R12

    property p_energyWrap;
        @(posedge core_clk) disable iff (!arst_n)
        av.done && !clrAcc |=> q.energy == (40'($past(q.energy) + $past(pwExt)) & ACC_MASK);
    endproperty
    a_energyWrap: assert property (p_energyWrap) else $error("energy sum wrong"); // see R8

    property p_clearAcc;
        @(posedge core_clk) disable iff (!arst_n)
        clrAcc && !av.done |=> q.energy == 40'h0 && q.charge == 40'h0 && !chargeOverflow;
    endproperty
    a_clearAcc: assert property (p_clearAcc) else $error("clear left accumulators"); // see R9

    property p_chargeOfSet;
        @(posedge core_clk) disable iff (!arst_n)
        av.done && chgCarry |=> chargeOverflow;
    endproperty
    a_chargeOfSet: assert property (p_chargeOfSet) else $error("overflow not flagged"); // see R10

    property p_chargeOfHold;
        @(posedge core_clk) disable iff (!arst_n)
        chargeOverflow && !clrAcc |=> chargeOverflow;
    endproperty
    a_chargeOfHold: assert property (p_chargeOfHold) else $error("overflow flag lost"); // see R16

    property p_sameSample;
        @(posedge core_clk) disable iff (!arst_n)
        av.done |=> q.power == $past(pw) && q.current == $past(av.avgCur);
    endproperty
    a_sameSample: assert property (p_sameSample) else $error("results from mixed samples"); // see R15

    property p_byteCount;
        @(posedge core_clk) disable iff (!arst_n)
        rdStart |=> q.bytesLeft == regBytes($past(q.ptr));
    endproperty
    a_byteCount: assert property (p_byteCount) else $error("wrong byte count"); // see R1

    property p_msbFirst;
        @(posedge core_clk) disable iff (!arst_n)
        (rdStart && !ptrWr && q.ptr == `REG_CURRENT && !av.done) ##1 (byteRd && !rdStart && !av.done)
            |=> byteValid && byteData == $past(q.current[15:8]);
    endproperty
    a_msbFirst: assert property (p_msbFirst) else $error("first byte not msb"); // see R14

    c_clear: cover property (@(posedge core_clk) disable iff (!arst_n) clrAcc);
    c_overflow: cover property (@(posedge core_clk) disable iff (!arst_n) av.done && chgCarry);
    c_readEnergy: cover property (@(posedge core_clk) disable iff (!arst_n)
        rdStart && q.ptr == `REG_ENERGY);
endmodule : power_monitor_result_registers
`default_nettype wire

// ===== dv/adc_model.sv
`timescale 1ns/10ps
`default_nettype none
module adc_model (
    // clock
    input wire logic core_clk,
    // sample request from the bench
    input wire logic fire,
    input wire logic [15:0] cur,
    input wire logic [15:0] bus,
    input wire logic [11:0] temp,
    // converter outputs
    output logic adcValid,
    output logic [15:0] adcCurrent,
    output logic [15:0] adcBus,
    output logic [11:0] adcTemp
);
    // codes mean nothing without the strobe, so idle data toggles to expose early sampling
    always @(posedge core_clk) begin
        adcValid <= fire;
        if (fire) begin
            {adcCurrent, adcBus, adcTemp} <= {cur, bus, temp};
        end else begin
            {adcCurrent, adcBus, adcTemp} <= ~{adcCurrent, adcBus, adcTemp};
        end
    end
endmodule : adc_model
`default_nettype wire

// ===== dv/power_monitor_result_registers_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module power_monitor_result_registers_tb_top;
    logic core_clk = 1'b0, arst_n = 1'b0, convStart, adcValid, byteValid, chargeOverflow;
    logic ptrWr = 1'b0, cfgWr = 1'b0, rdStart = 1'b0, byteRd = 1'b0, fire = 1'b0;
    logic [7:0] ptrData = 8'h00, cfgData = 8'h00, byteData;
    logic [15:0] adcCurrent, adcBus, cur = 16'h0, bus = 16'h0, c, b, mc, be;
    logic [11:0] adcTemp, temp = 12'h0, t;
    logic signed [25:0] sc, sb;
    logic signed [21:0] st;
    logic [23:0] p;
    logic [39:0] v, eng, chg;
    logic ovf;
    // narrow accumulators so wrap and charge carry happen within the run
    localparam int ACC_W = 17;
    int num_errors = 0, comparisons = 0, cycles = 0, s, n;
    int convUs[8] = '{50, 84, 150, 280, 540, 1052, 2074, 4120};

    power_monitor_result_registers #(.CYC_PER_US(1), .ACC_W(ACC_W)) power_monitor_result_registers_i (
        .core_clk(core_clk), .arst_n(arst_n), .convStart(convStart), .adcValid(adcValid),
        .adcCurrent(adcCurrent), .adcBus(adcBus), .adcTemp(adcTemp), .ptrWr(ptrWr),
        .ptrData(ptrData), .cfgWr(cfgWr), .cfgData(cfgData), .rdStart(rdStart),
        .byteRd(byteRd), .byteData(byteData), .byteValid(byteValid),
        .chargeOverflow(chargeOverflow));
    adc_model adc_model_i (.core_clk(core_clk), .fire(fire), .cur(cur), .bus(bus),
        .temp(temp), .adcValid(adcValid), .adcCurrent(adcCurrent), .adcBus(adcBus),
        .adcTemp(adcTemp));

    // 200 MHz clock
    initial begin
        forever #2.5 core_clk = ~core_clk;
    end

    // hang guard, well above the expected run length
    always @(posedge core_clk) begin
        cycles++;
        if (cycles > 80000) begin
            num_errors++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // pointer, snapshot, then one byte per two cycles; bytes shift in from the right
    task automatic rd(input logic [7:0] a, input int nb);
        v = '0;
        @(posedge core_clk);
        ptrWr <= 1'b1;
        ptrData <= a;
        @(posedge core_clk);
        ptrWr <= 1'b0;
        rdStart <= 1'b1;
        @(posedge core_clk);
        rdStart <= 1'b0;
        for (int i = 0; i < nb; i++) begin
            byteRd <= 1'b1;
            @(posedge core_clk);
            byteRd <= 1'b0;
            #1 chk({39'h0, byteValid}, 40'h1);
            v = {v[31:0], byteData};
            @(posedge core_clk);
        end
    endtask : rd

    task automatic cfg(input logic [7:0] d);
        @(posedge core_clk);
        cfgWr <= 1'b1;
        cfgData <= d;
        @(posedge core_clk);
        cfgWr <= 1'b0;
    endtask : cfg

    task automatic samp(input logic [15:0] ci, input logic [15:0] bi, input logic [11:0] ti);
        @(posedge core_clk);
        fire <= 1'b1;
        cur <= ci;
        bus <= bi;
        temp <= ti;
        @(posedge core_clk);
        fire <= 1'b0;
    endtask : samp

    // counts edges until convStart is seen, bounded; looks once the edge has settled
    task automatic waitConv(output int k);
        k = 0;
        do begin
            @(posedge core_clk);
            #1 k++;
        end while (convStart !== 1'b1 && k < 9000);
    endtask : waitConv

    function automatic logic [16:0] absv(input logic [15:0] i);
        return i[15] ? 17'h0 - {1'b1, i} : {1'b0, i};
    endfunction : absv

    // power from magnitude of current and the clamped bus code
    function automatic logic [23:0] pwr(input logic [15:0] i, input logic [15:0] bv);
        return 24'((34'(absv(i)) * 34'(bv)) >> 6);
    endfunction : pwr

    // one result update: energy wraps, a charge carry raises the sticky flag
    task automatic accum(input logic [15:0] ci, input logic [15:0] bv);
        eng = (eng + 40'(pwr(ci, bv))) & ((40'h1 << ACC_W) - 40'h1);
        chg += 40'(absv(ci));
        if (chg >= (40'h1 << ACC_W)) begin
            chg -= 40'h1 << ACC_W;
            ovf = 1'b1;
        end
    endtask : accum

    // main sequence
    initial begin
        void'($urandom(55237));
        repeat (6) @(posedge core_clk);
        arst_n <= 1'b1;
        rd(8'h00, 2);
        chk(v, 40'h0028);
        rd(8'h05, 2);
        chk(v, 40'h0);
        rd(8'h33, 2);
        chk(v, 40'h0);
        eng = '0;
        chg = '0;
        ovf = 1'b0;
        for (s = 0; s < 4; s++) begin
            cfg(8'(s));
            rd(8'h00, 2);
            chk(v, 40'(s) | {31'h0, ovf, 8'h00});
            for (int r = 0; r < 5; r++) begin
                sc = '0;
                sb = '0;
                st = '0;
                repeat (1 << (2 * s)) begin
                    c = 16'($urandom);
                    b = 16'($urandom);
                    t = 12'($urandom);
                    // full-scale corners: most negative current, top bus code, -256 degrees
                    if (r == 0 && s == 0) {c, b, t} = {16'h8000, 16'h7fff, 12'h800};
                    sc += 26'(signed'(c));
                    sb += 26'(signed'(b));
                    st += 22'(signed'(t));
                    samp(c, b, t);
                end
                repeat (4) @(posedge core_clk);
                mc = 16'(sc >>> (2 * s));
                be = 16'(sb >>> (2 * s));
                be = be[15] ? 16'h0 : be;
                t = 12'(st >>> (2 * s));
                p = pwr(mc, be);
                accum(mc, be);
                rd(8'h07, 2);
                chk(v, 40'(mc));
                rd(8'h05, 3);
                chk(v, {16'h0, be, 8'h00});
                rd(8'h06, 2);
                chk(v, {28'h0, t});
                rd(8'h08, 3);
                chk(v, 40'(p));
                rd(8'h09, 5);
                chk(v, eng);
                rd(8'h0a, 5);
                chk(v, chg);
                chk({39'h0, chargeOverflow}, {39'h0, ovf});
            end
        end
        // five full-scale samples force a charge carry from any starting total
        cfg(8'h00);
        repeat (5) begin
            samp(16'h8000, 16'h0100, 12'h000);
            accum(16'h8000, 16'h0100);
        end
        repeat (4) @(posedge core_clk);
        chk({39'h0, chargeOverflow}, 40'h1);
        rd(8'h0a, 5);
        chk(v, chg);
        rd(8'h09, 5);
        chk(v, eng);
        cfg(8'h80);
        rd(8'h09, 5);
        chk(v, 40'h0);
        rd(8'h0a, 5);
        chk(v, 40'h0);
        chk({39'h0, chargeOverflow}, 40'h0);
        for (s = 0; s < 8; s++) begin
            cfg(8'(s << 3));
            repeat (2) waitConv(n);
            waitConv(n);
            chk(40'(n), 40'(convUs[s]));
        end
        print_verdict();
    end
endmodule : power_monitor_result_registers_tb_top
`default_nettype wire
